// ==== pmcg_map.vh ====
// Register map, field layout and timing constants of the power-mode clock controller
//
// Operation
// - Firmware can divide the CPU clock and gate each peripheral clock on its own.
// - The master clock divisor runs from 1 to 1024 and can change without stopping clocks.
// - Firmware can switch the master clock source to the 32.768 kHz real-time clock at any time.
// - In Run mode every clock runs except those masked off by firmware.
// - Any reset brings the controller up in Run mode.
// - An optional interrupt mode runs the CPU at full speed during service, then restores the divisor.
// - Setting the idle request stops the CPU and flash clocks at once.
// - In Idle the CPU and flash clocks stay stopped until an interrupt, reset or wake event.
// - In Idle the peripheral clocks follow the mask captured when Idle was entered.
// - Any reset source returns Idle to Run.
// - Any interrupt or wake-unit input returns Idle to Run.
// - Sleep stops every clock but the real-time clock, keeps the wake unit powered, forces the PLL off.
// - Sleep also disables the main oscillator input.
// - Leaving Sleep needs the real-time clock to be running, unless the debug port is active.
// - Sleep is left only on pin, low-voltage, power-up or debug reset, RTC alarm, wake input or an active debug port.
// - While the debug port is active no clock is ever gated off.
`ifndef PMCG_MAP_VH
`define PMCG_MAP_VH

// Register indices on the plain register port
`define PMCG_ADDR_W 4
`define PMCG_REG_CTRL 4'h0
`define PMCG_REG_DIV 4'h1
`define PMCG_REG_MASK 4'h2
`define PMCG_REG_IDLE_MASK 4'h3
`define PMCG_REG_STATUS 4'h4

// Control register fields
`define PMCG_CTRL_IDLE 0
`define PMCG_CTRL_SLEEP 1
`define PMCG_CTRL_RTC_SRC 2
`define PMCG_CTRL_INT_MODE 3

// Status register fields
`define PMCG_STAT_MODE_LO 0
`define PMCG_STAT_MODE_HI 1
`define PMCG_STAT_FULL 2

// Divisor field is a value minus one, ten bits wide
`define PMCG_DIV_W 10
`define PMCG_DIV_RST 10'h000

// Mode encoding
`define PMCG_MODE_RUN 2'h0
`define PMCG_MODE_IDLE 2'h1
`define PMCG_MODE_SLEEP 2'h2

`endif

// ==== pmcg_ctrl.v ====
// Power-mode sequencer and clock-gating controller
`timescale 1ns/100ps
`default_nettype none
`include "pmcg_map.vh"

module pmcg_ctrl #(
  parameter PERIPH_N = 8
) (
  input wire clk_in,
  input wire srst_in,
  input wire [`PMCG_ADDR_W-1:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire rtc_clk_in,
  input wire rtc_alive_in,
  input wire irq_in,
  input wire irq_active_in,
  input wire rtc_alarm_in,
  input wire wake_in,
  input wire rst_pin_in,
  input wire rst_wdog_in,
  input wire rst_lvd_in,
  input wire rst_por_in,
  input wire rst_dbg_in,
  input wire dbg_active_in,
  output reg cpu_clk_en_out,
  output reg flash_clk_en_out,
  output reg bus_clk_en_out,
  output reg [PERIPH_N-1:0] periph_clk_en_out,
  output reg rtc_sel_out,
  output reg pll_off_out,
  output reg main_osc_en_out,
  output reg wake_pwr_out,
  output reg [1:0] mode_out
);

  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg idle_req_r;
  reg sleep_req_r;
  reg rtc_src_r;
  reg int_mode_r;
  reg [`PMCG_DIV_W-1:0] div_r;
  reg [`PMCG_DIV_W-1:0] cnt_r;
  reg [PERIPH_N-1:0] mask_r;
  reg [PERIPH_N-1:0] idle_mask_r;
  reg [PERIPH_N-1:0] held_mask_r;
  reg [4:0] rs1_r;
  reg [4:0] rs2_r;
  reg [3:0] ws1_r;
  reg [3:0] ws2_r;
  wire any_rst;
  wire sleep_rst;
  wire full_speed;
  wire tick;
  wire dbg_on;
  wire rtc_ok;
  wire irq_s;
  wire irq_act_s;
  wire alarm_s;
  wire wake_s;
  wire wr_ctrl;

  // Write strobe aimed at one register index; shared by every register write decode
  function reg_hit;
    input [`PMCG_ADDR_W-1:0] idx;
    begin
      reg_hit = wr_in && (addr_in == idx);
    end
  endfunction

  // Two-stage synchronisers; second stage is the only one read
  always @(posedge clk_in) begin
    if (srst_in) begin
      rs1_r <= 5'h00;
      rs2_r <= 5'h00;
      ws1_r <= 4'h0;
      ws2_r <= 4'h0;
    end else begin
      rs1_r <= {rst_dbg_in, rst_por_in, rst_lvd_in, rst_wdog_in, rst_pin_in};
      rs2_r <= rs1_r;
      ws1_r <= {rtc_alive_in, wake_in, rtc_alarm_in, irq_in};
      ws2_r <= ws1_r;
    end
  end

  assign irq_s = ws2_r[0];
  assign alarm_s = ws2_r[1];
  assign wake_s = ws2_r[2];
  assign rtc_ok = ws2_r[3];
  assign irq_act_s = irq_active_in;
  assign dbg_on = dbg_active_in;
  assign any_rst = |rs2_r;
  // Watchdog left out on purpose: it cannot restart a sleeping chip
  assign sleep_rst = rs2_r[0] | rs2_r[2] | rs2_r[3] | rs2_r[4];
  assign wr_ctrl = reg_hit(`PMCG_REG_CTRL);

  // Mode sequencer
  always @* begin
    mode_nxt = mode_r;
    case (mode_r)
      `PMCG_MODE_RUN: begin
        if (wr_ctrl && wdata_in[`PMCG_CTRL_SLEEP] && !dbg_on) begin
          mode_nxt = `PMCG_MODE_SLEEP;
        end else if (wr_ctrl && wdata_in[`PMCG_CTRL_IDLE] && !dbg_on) begin
          mode_nxt = `PMCG_MODE_IDLE;
        end
      end
      `PMCG_MODE_IDLE: begin
        if (any_rst || irq_s || alarm_s || wake_s || dbg_on) begin
          mode_nxt = `PMCG_MODE_RUN;
        end
      end
      `PMCG_MODE_SLEEP: begin
        // Source exits wait for rtc_ok; an active debug port leaves Sleep even with a dead RTC
        if (rtc_ok && (sleep_rst || alarm_s || wake_s)) begin
          mode_nxt = `PMCG_MODE_RUN;
        end else if (dbg_on) begin
          mode_nxt = `PMCG_MODE_RUN;
        end
      end
      default: begin
        mode_nxt = `PMCG_MODE_RUN;
      end
    endcase
  end

  // Software registers and mode state
  always @(posedge clk_in) begin
    if (srst_in) begin
      mode_r <= `PMCG_MODE_RUN;
      idle_req_r <= 1'b0;
      sleep_req_r <= 1'b0;
      rtc_src_r <= 1'b0;
      int_mode_r <= 1'b0;
      div_r <= `PMCG_DIV_RST;
      mask_r <= {PERIPH_N{1'b1}};
      idle_mask_r <= {PERIPH_N{1'b1}};
      held_mask_r <= {PERIPH_N{1'b1}};
    end else begin
      mode_r <= mode_nxt;
      if (wr_ctrl) begin
        idle_req_r <= wdata_in[`PMCG_CTRL_IDLE];
        sleep_req_r <= wdata_in[`PMCG_CTRL_SLEEP];
        rtc_src_r <= wdata_in[`PMCG_CTRL_RTC_SRC];
        int_mode_r <= wdata_in[`PMCG_CTRL_INT_MODE];
      end
      if (mode_r != `PMCG_MODE_RUN && mode_nxt == `PMCG_MODE_RUN) begin
        idle_req_r <= 1'b0;
        sleep_req_r <= 1'b0;
      end
      if (reg_hit(`PMCG_REG_DIV)) begin
        div_r <= wdata_in[`PMCG_DIV_W-1:0];
      end
      if (reg_hit(`PMCG_REG_MASK)) begin
        mask_r <= wdata_in[PERIPH_N-1:0];
      end
      if (reg_hit(`PMCG_REG_IDLE_MASK)) begin
        idle_mask_r <= wdata_in[PERIPH_N-1:0];
      end
      // Freeze the idle mask at the instant Idle is entered
      if (mode_r == `PMCG_MODE_RUN && mode_nxt == `PMCG_MODE_IDLE) begin
        held_mask_r <= idle_mask_r;
      end
    end
  end

  // Master divider; new divisor is compared against the running count at once, clock never stops
  assign full_speed = int_mode_r && irq_act_s;
  assign tick = full_speed || (cnt_r >= div_r);
  always @(posedge clk_in) begin
    if (srst_in) begin
      cnt_r <= `PMCG_DIV_RST;
    end else if (tick) begin
      cnt_r <= `PMCG_DIV_RST;
    end else begin
      cnt_r <= cnt_r + 10'h001;
    end
  end

  // Clock enables, all registered
  always @(posedge clk_in) begin
    if (srst_in) begin
      cpu_clk_en_out <= 1'b0;
      flash_clk_en_out <= 1'b0;
      bus_clk_en_out <= 1'b0;
      periph_clk_en_out <= {PERIPH_N{1'b0}};
      rtc_sel_out <= 1'b0;
      pll_off_out <= 1'b0;
      main_osc_en_out <= 1'b1;
      wake_pwr_out <= 1'b1;
      mode_out <= `PMCG_MODE_RUN;
    end else begin
      mode_out <= mode_nxt;
      rtc_sel_out <= rtc_src_r;
      wake_pwr_out <= 1'b1;
      if (dbg_on) begin
        cpu_clk_en_out <= tick;
        flash_clk_en_out <= tick;
        bus_clk_en_out <= tick;
        periph_clk_en_out <= {PERIPH_N{1'b1}};
        pll_off_out <= 1'b0;
        main_osc_en_out <= 1'b1;
      end else begin
        case (mode_nxt)
          `PMCG_MODE_RUN: begin
            cpu_clk_en_out <= tick;
            flash_clk_en_out <= tick;
            bus_clk_en_out <= tick;
            periph_clk_en_out <= mask_r;
            pll_off_out <= 1'b0;
            main_osc_en_out <= 1'b1;
          end
          `PMCG_MODE_IDLE: begin
            cpu_clk_en_out <= 1'b0;
            flash_clk_en_out <= 1'b0;
            bus_clk_en_out <= tick;
            periph_clk_en_out <= (mode_r == `PMCG_MODE_IDLE) ? held_mask_r : idle_mask_r;
            pll_off_out <= 1'b0;
            main_osc_en_out <= 1'b1;
          end
          default: begin
            cpu_clk_en_out <= 1'b0;
            flash_clk_en_out <= 1'b0;
            bus_clk_en_out <= 1'b0;
            periph_clk_en_out <= {PERIPH_N{1'b0}};
            pll_off_out <= 1'b1;
            main_osc_en_out <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read port, data one cycle after the strobe; unmapped reads zero
  always @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      case (addr_in)
        `PMCG_REG_CTRL: rdata_out <= {28'h0000000, int_mode_r, rtc_src_r, sleep_req_r, idle_req_r};
        `PMCG_REG_DIV: rdata_out <= {22'h000000, div_r};
        `PMCG_REG_MASK: rdata_out <= {{(32-PERIPH_N){1'b0}}, mask_r};
        `PMCG_REG_IDLE_MASK: rdata_out <= {{(32-PERIPH_N){1'b0}}, idle_mask_r};
        `PMCG_REG_STATUS: rdata_out <= {29'h00000000, full_speed, mode_r};
        default: rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ==== pmcg_src.sv ====
// Far-side model of the wake, interrupt and reset sources
`timescale 1ns/100ps
`default_nettype none
module pmcg_src (
  input wire logic clk_in,
  input wire logic [2:0] sel_in,
  input wire logic go_in,
  output logic [7:0] src_out
);
  logic [2:0] cnt_r = 3'h0;
  // Holds a source four cycles so it survives the synchroniser
  always @(posedge clk_in) begin
    if (go_in) begin
      cnt_r <= 3'h4;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  assign src_out = (cnt_r != 3'h0) ? (8'h01 << sel_in) : 8'h00;
endmodule
`default_nettype wire

// ==== pmcg_ctrl_assertions.sv ====
// Concurrent checks on the power-mode clock controller ports
`timescale 1ns/100ps
`default_nettype none
module pmcg_ctrl_assertions #(
  parameter PERIPH_N = 8
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic irq_in,
  input wire logic rtc_alive_in,
  input wire logic rst_wdog_in,
  input wire logic dbg_active_in,
  input wire logic cpu_clk_en_out,
  input wire logic flash_clk_en_out,
  input wire logic bus_clk_en_out,
  input wire logic [PERIPH_N-1:0] periph_clk_en_out,
  input wire logic pll_off_out,
  input wire logic main_osc_en_out,
  input wire logic wake_pwr_out,
  input wire logic [1:0] mode_out
);
  // Single domain, clock and reset given once
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_reset_run: assert property (disable iff (1'b0) srst_in |=> mode_out == 2'h0)
    else $error("mode not run after reset");
  a_idle_entry: assert property (wr_in && addr_in == 4'h0 && wdata_in[1:0] == 2'b01
    && mode_out == 2'h0 && !dbg_active_in && !irq_in |=> mode_out == 2'h1)
    else $error("idle not entered");
  a_idle_gated: assert property (mode_out == 2'h1 && !dbg_active_in
    |-> !cpu_clk_en_out && !flash_clk_en_out) else $error("cpu clock runs in idle");
  a_idle_irq: assert property ($rose(irq_in) && mode_out == 2'h1
    |-> ##[1:4] mode_out == 2'h0) else $error("irq did not wake idle");
  a_idle_wdog: assert property ($rose(rst_wdog_in) && mode_out == 2'h1
    |-> ##[1:4] mode_out == 2'h0) else $error("watchdog did not wake idle");
  a_sleep_off: assert property (mode_out == 2'h2 |-> pll_off_out && !main_osc_en_out
    && !cpu_clk_en_out && !bus_clk_en_out && periph_clk_en_out == '0)
    else $error("clock left on in sleep");
  a_wake_power: assert property (wake_pwr_out)
    else $error("wake unit unpowered");
  a_sleep_wdog: assert property ($rose(rst_wdog_in) && mode_out == 2'h2
    |=> (mode_out == 2'h2) [*4]) else $error("watchdog left sleep");
  a_rtc_needed: assert property ((mode_out == 2'h2 && !rtc_alive_in) [*3]
    |=> mode_out == 2'h2) else $error("sleep left without rtc");
  a_dbg_run: assert property (dbg_active_in [*4] |-> mode_out == 2'h0)
    else $error("gated while debug active");
endmodule
bind pmcg_ctrl pmcg_ctrl_assertions #(.PERIPH_N(PERIPH_N)) pmcg_ctrl_assertions_i (.clk_in,
  .srst_in, .addr_in, .wdata_in, .wr_in, .irq_in, .rtc_alive_in, .rst_wdog_in, .dbg_active_in,
  .cpu_clk_en_out, .flash_clk_en_out, .bus_clk_en_out, .periph_clk_en_out, .pll_off_out,
  .main_osc_en_out, .wake_pwr_out, .mode_out);
`default_nettype wire

// ==== pmcg_ctrl_bench.sv ====
// Directed testbench for the power-mode clock controller
`timescale 1ns/100ps
`default_nettype none
module pmcg_ctrl_bench;
  logic clk_in, srst_in, wr_in, rd_in, rtc_alive_in, irq_active_in, dbg_active_in, go;
  logic [3:0] addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [2:0] sel;
  logic [7:0] src, periph_clk_en_out;
  logic [1:0] mode_out;
  logic cpu_clk_en_out, flash_clk_en_out, bus_clk_en_out, rtc_sel_out, pll_off_out;
  logic main_osc_en_out, wake_pwr_out;
  int bad_count, cmp_count, k, i;
  pmcg_src pmcg_src_i (.clk_in, .sel_in(sel), .go_in(go), .src_out(src));
  pmcg_ctrl pmcg_ctrl_i (.clk_in, .srst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rtc_clk_in(1'b0), .rtc_alive_in, .irq_in(src[0]), .irq_active_in, .rtc_alarm_in(src[1]),
    .wake_in(src[2]), .rst_pin_in(src[3]), .rst_wdog_in(src[4]), .rst_lvd_in(src[5]),
    .rst_por_in(src[6]), .rst_dbg_in(src[7]), .dbg_active_in, .cpu_clk_en_out,
    .flash_clk_en_out, .bus_clk_en_out, .periph_clk_en_out, .rtc_sel_out, .pll_off_out,
    .main_osc_en_out, .wake_pwr_out, .mode_out);
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task fire(input logic [2:0] s);
    @(posedge clk_in);
    sel <= s;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
  endtask
  // Counts cpu enable pulses, unknown counts as none
  task cnt(input int n);
    k = 0;
    repeat (n) begin
      @(negedge clk_in);
      k += (cpu_clk_en_out === 1'b1);
    end
  endtask
  task t_reset;
    chk(mode_out, 2'h0);
    rd(4'h1);
    chk(d, 32'h0);
    rd(4'h2);
    chk(d[7:0], 8'hff);
    wr(4'h5, 32'h1);
    rd(4'h5);
    chk(d, 32'h0);
    wr(4'h0, 32'h1);
    @(posedge clk_in);
    srst_in <= 1'b1;
    @(posedge clk_in);
    srst_in <= 1'b0;
    cyc(1);
    chk(mode_out, 2'h0);
    $display("reset test done");
  endtask
  task t_run;
    wr(4'h2, 32'h5a);
    cyc(2);
    chk(periph_clk_en_out, 8'h5a);
    wr(4'h0, 32'h4);
    cyc(2);
    chk(rtc_sel_out, 1'b1);
    wr(4'h1, 32'h3);
    wr(4'h0, 32'h8);
    cyc(2);
    cnt(40);
    chk(k, 10);
    @(posedge clk_in);
    irq_active_in <= 1'b1;
    cyc(3);
    cnt(20);
    chk(k, 20);
    rd(4'h4);
    chk(d, 32'h4);
    @(posedge clk_in);
    irq_active_in <= 1'b0;
    cyc(3);
    cnt(20);
    chk(k, 5);
    wr(4'h1, 32'h3ff);
    rd(4'h1);
    chk(d, 32'h3ff);
    wr(4'h1, 32'h0);
    wr(4'h2, 32'hff);
    wr(4'h0, 32'h0);
    $display("run test done");
  endtask
  // Every source in turn wakes idle
  task t_idle;
    for (i = 0; i < 8; i++) begin
      wr(4'h3, 32'h0f);
      wr(4'h0, 32'h1);
      cyc(2);
      chk(mode_out, 2'h1);
      chk({cpu_clk_en_out, flash_clk_en_out}, 2'h0);
      chk(periph_clk_en_out, 8'h0f);
      cyc(8);
      chk(mode_out, 2'h1);
      fire(i[2:0]);
      cyc(6);
      chk(mode_out, 2'h0);
      rd(4'h0);
      chk(d[0], 1'b0);
    end
    $display("idle test done");
  endtask
  // The watchdog alone must not end sleep
  task t_sleep;
    @(posedge clk_in);
    rtc_alive_in <= 1'b1;
    for (i = 1; i < 8; i++) begin
      wr(4'h0, 32'h2);
      cyc(2);
      chk({pll_off_out, main_osc_en_out, cpu_clk_en_out, bus_clk_en_out, periph_clk_en_out},
        12'h800);
      fire(i[2:0]);
      cyc(6);
      chk(mode_out, (i == 4) ? 2'h2 : 2'h0);
    end
    @(posedge clk_in);
    rtc_alive_in <= 1'b0;
    wr(4'h0, 32'h2);
    fire(3'h2);
    cyc(6);
    chk(mode_out, 2'h2);
    @(posedge clk_in);
    rtc_alive_in <= 1'b1;
    fire(3'h2);
    cyc(6);
    chk(mode_out, 2'h0);
    $display("sleep test done");
  endtask
  task t_dbg;
    @(posedge clk_in);
    dbg_active_in <= 1'b1;
    wr(4'h0, 32'h3);
    cyc(4);
    chk({mode_out, cpu_clk_en_out, flash_clk_en_out}, 4'h3);
    @(posedge clk_in);
    dbg_active_in <= 1'b0;
    wr(4'h0, 32'h0);
    $display("debug test done");
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {srst_in, wr_in, rd_in, go, rtc_alive_in, irq_active_in, dbg_active_in} = 7'h40;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    sel = 3'h0;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    cyc(1);
    t_reset;
    t_run;
    t_idle;
    t_sleep;
    t_dbg;
    summarize;
  end
  // Watchdog against a hung handshake
  initial begin
    #400000;
    bad_count++;
    summarize;
  end
endmodule
`default_nettype wire
